// *** hdl/daisy_chain_spi_slave.sv ***
// serial slave front end with daisy-chain frame length check
// assumes link pins asynchronous to clk; serial clock at most 5 MHz
`timescale 1ns/10ps
module daisy_chain_spi_slave
  import spi_chain_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // serial link
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // device side
  input wire logic sleep_mode,
  input wire frame_s response_word,
  input wire logic error_clear,
  output logic frame_length_error_flag,
  // received frames
  output logic frame_valid,
  input wire logic frame_ready,
  output frame_s frame_word
);
  logic [SYNC_STAGES-1:0] cs_sync_q;
  logic [SYNC_STAGES-1:0] sck_sync_q;
  logic [SYNC_STAGES-1:0] si_sync_q;
  logic cs_q;
  logic sck_q;
  logic cs_fall;
  logic cs_rise;
  logic sck_fall;
  logic sck_rise;
  link_state_e state_q;
  logic [15:0] shift_q;
  logic [CNT_BITS-1:0] cnt_q;
  logic so_q;
  logic oe_q;
  logic err_q;
  logic push_q;
  frame_s push_data_q;
  logic buf_ready;
  logic buf_valid;
  frame_s buf_data;
  logic valid_q;
  frame_s word_q;
  logic good_len;

  // ----------------------------------------------------------------
  // synchronisers and edge finding
  // ----------------------------------------------------------------
  // first stage feeds only the second stage; edges are found on stage two
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_sync_q <= 2'h3;
      sck_sync_q <= 2'h0;
      si_sync_q <= 2'h0;
      cs_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      cs_sync_q <= {cs_sync_q[0], chip_select_n};
      sck_sync_q <= {sck_sync_q[0], serial_clk};
      si_sync_q <= {si_sync_q[0], serial_in};
      cs_q <= cs_sync_q[1];
      sck_q <= sck_sync_q[1];
    end
  end

  assign cs_fall = cs_q && !cs_sync_q[1];
  assign cs_rise = !cs_q && cs_sync_q[1];
  // clock edges count only while selected
  assign sck_fall = sck_q && !sck_sync_q[1] && (state_q == LINK_ACTIVE);
  assign sck_rise = !sck_q && sck_sync_q[1] && (state_q == LINK_ACTIVE);
  // 16 pulses, then whole groups of 8, up to 56 in all; the count stops at 63
  assign good_len = (cnt_q >= FIRST_WORD) && ((cnt_q[2:0] & GROUP_MASK) == 3'h0);

  // ----------------------------------------------------------------
  // access state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= LINK_IDLE;
    end else begin
      case (state_q)
        LINK_IDLE: begin
          if (cs_fall) begin
            state_q <= sleep_mode ? LINK_MUTE : LINK_ACTIVE;
          end
        end
        LINK_ACTIVE, LINK_MUTE: begin
          if (cs_rise) begin
            state_q <= LINK_IDLE;
          end
        end
        default: state_q <= LINK_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // shift register and pulse counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_q <= WORD_RST;
      cnt_q <= CNT_RST;
    end else if (cs_fall) begin
      shift_q <= response_word;
      cnt_q <= CNT_RST;
    end else if (sck_fall) begin
      shift_q <= {shift_q[14:0], si_sync_q[1]};
      if (cnt_q != CNT_MAX) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  // the chain error bit comes out before the first rising edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      if (cs_fall && !sleep_mode) begin
        oe_q <= 1'b1;
        so_q <= err_q | si_sync_q[1];
      end else if (cs_rise || state_q != LINK_ACTIVE) begin
        oe_q <= 1'b0;
      end else if (sck_rise) begin
        so_q <= shift_q[15];
      end
    end
  end

  // ----------------------------------------------------------------
  // frame check and hand-off
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_q <= 1'b0;
    end else if (cs_rise && state_q == LINK_ACTIVE && !good_len) begin
      err_q <= 1'b1;
    end else if (error_clear) begin
      err_q <= 1'b0;
    end
  end

  // a full buffer drops the frame; limitation accepted, receiver drains fast
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      push_q <= 1'b0;
      push_data_q <= WORD_RST;
    end else begin
      push_q <= cs_rise && state_q == LINK_ACTIVE && good_len;
      if (cs_rise) begin
        push_data_q <= shift_q;
      end
    end
  end

  frame_buffer u_buf (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(push_q),
    .in_ready(buf_ready),
    .in_data(push_data_q),
    .out_valid(buf_valid),
    .out_ready(!valid_q || frame_ready),
    .out_data(buf_data)
  );

  // output stage registered so outputs come from flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      valid_q <= 1'b0;
      word_q <= WORD_RST;
    end else if (!valid_q || frame_ready) begin
      valid_q <= buf_valid;
      word_q <= buf_data;
    end
  end

  assign serial_out = so_q;
  assign serial_out_oe = oe_q;
  assign frame_length_error_flag = err_q;
  assign frame_valid = valid_q;
  assign frame_word = word_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_RELEASE_DESEL: assert property (@(posedge clk) disable iff (!arst_n)
    cs_rise |=> !serial_out_oe) else $error("data out not released on deselect");
  AST_SLEEP_MUTE: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == LINK_MUTE) |-> !serial_out_oe) else $error("data out driven in sleep");
  AST_COUNT_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
    cs_fall |=> (cnt_q == CNT_RST)) else $error("count not cleared");
  AST_BAD_LEN: assert property (@(posedge clk) disable iff (!arst_n)
    (cs_rise && state_q == LINK_ACTIVE && !good_len) |=> err_q && !push_q)
    else $error("bad frame not flagged");
  AST_GOOD_PUSH: assert property (@(posedge clk) disable iff (!arst_n)
    (cs_rise && state_q == LINK_ACTIVE && good_len) |=> push_q && push_data_q == $past(shift_q))
    else $error("good frame not passed on");
  AST_ERR_OUT: assert property (@(posedge clk) disable iff (!arst_n)
    (cs_fall && !sleep_mode && err_q) |=> serial_out && serial_out_oe)
    else $error("error bit not shown at select");
  AST_MSB_OUT: assert property (@(posedge clk) disable iff (!arst_n)
    (sck_rise && !cs_rise) |=> serial_out == $past(shift_q[15]))
    else $error("wrong bit shifted out");
  AST_SHIFT_IN: assert property (@(posedge clk) disable iff (!arst_n)
    (sck_fall && !cs_fall) |=> shift_q[0] == $past(si_sync_q[1]))
    else $error("bit not shifted in");
  // a full buffer only ever stands behind a stalled output stage
  AST_BUF_FULL: assert property (@(posedge clk) disable iff (!arst_n)
    (push_q && !buf_ready) |-> valid_q)
    else $error("frame dropped while output stage empty");
endmodule : daisy_chain_spi_slave

// *** hdl/frame_buffer.sv ***
// two-entry buffer for received frames
// assumes producer and consumer share clk; ready/valid on both sides
`timescale 1ns/10ps
module frame_buffer
  import spi_chain_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire frame_s in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output frame_s out_data
);
  frame_s mem_q [BUF_DEPTH];
  logic wr_q;
  logic rd_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule : frame_buffer

// *** hdl/spi_chain_pkg.sv ***
// package for the daisy-chain serial slave front end
// assumes a single system clock of 40 MHz; no register bus
package spi_chain_pkg;
  localparam int WORD_BITS = 16;
  localparam int GROUP_BITS = 8;
  localparam int CNT_BITS = 6;
  localparam logic [CNT_BITS-1:0] CNT_RST = 6'h00;
  localparam logic [CNT_BITS-1:0] CNT_MAX = 6'h3F;
  localparam logic [CNT_BITS-1:0] FIRST_WORD = 6'h10;
  localparam logic [2:0] GROUP_MASK = 3'h7;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam int SYNC_STAGES = 2;
  localparam int BUF_DEPTH = 2;

  typedef struct packed {
    logic [7:0] command;
    logic [7:0] data;
  } frame_s;

  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_ACTIVE,
    LINK_MUTE
  } link_state_e;
endpackage : spi_chain_pkg

// *** test/spi_master_model.sv ***
// serial master model that drives the slave's link pins from tasks
// assumes clk is the 40 MHz system clock; one serial clock period is 8 clk (200 ns)
`timescale 1ns/10ps
module spi_master_model (
  // system clock
  input wire logic clk,
  // link
  output logic chip_select_n,
  output logic serial_clk,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
  end

  task automatic wait_clk(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : wait_clk

  // shifts n bits of w out, msb first, and collects what comes back
  task automatic xfer(input int n, input logic [63:0] w, input logic si0,
      output logic [63:0] got, output logic so0, output logic oe0);
    got = 64'h0;
    serial_in = si0;
    chip_select_n = 1'b0;
    wait_clk(8);
    so0 = serial_out;
    oe0 = serial_out_oe;
    for (int i = n - 1; i >= 0; i--) begin
      serial_clk = 1'b1;
      serial_in = w[i];
      wait_clk(4);
      serial_clk = 1'b0;
      wait_clk(4);
      // a released pin reads as the inverse of the last bit, not as a kind 0
      got = {got[62:0], serial_out_oe ? serial_out : ~got[0]};
    end
    wait_clk(8);
    chip_select_n = 1'b1;
    serial_in = ~serial_in;
    wait_clk(12);
  endtask : xfer

  // clock and data activity while deselected
  task automatic noise(input int k);
    for (int i = 0; i < k; i++) begin
      serial_clk = ~serial_clk;
      serial_in = 1'($urandom_range(1));
      wait_clk(4);
    end
    serial_clk = 1'b0;
    wait_clk(12);
  endtask : noise
endmodule : spi_master_model

// *** test/testbench.sv ***
// self-checking bench for the daisy-chain serial slave
// assumes the master model stands on the link; frames are drained here
`timescale 1ns/10ps
module testbench
  import spi_chain_pkg::*;
;
  logic clk, arst_n, chip_select_n, serial_clk, serial_in, serial_out, serial_out_oe;
  logic sleep_mode, error_clear, frame_length_error_flag, frame_valid, frame_ready;
  frame_s response_word, frame_word;
  int failures, samples_checked;
  int cycles = 0;
  int lens[7] = '{16, 12, 24, 8, 17, 32, 40};
  logic [15:0] exp_q[$];
  logic flag_exp;

  daisy_chain_spi_slave daisy_chain_spi_slave_i (.clk(clk), .arst_n(arst_n),
    .chip_select_n(chip_select_n), .serial_clk(serial_clk), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .sleep_mode(sleep_mode),
    .response_word(response_word), .error_clear(error_clear),
    .frame_length_error_flag(frame_length_error_flag), .frame_valid(frame_valid),
    .frame_ready(frame_ready), .frame_word(frame_word));
  spi_master_model spi_master_model_i (.clk(clk), .chip_select_n(chip_select_n),
    .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic good_len(input int n);
    return n >= 16 && n % 8 == 0;
  endfunction : good_len

  // generous ceiling: the whole sequence needs well under 15000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      complete_run();
    end
  end

  // looked at mid-cycle, where the handshake of the coming edge stands settled
  always @(negedge clk) begin
    if (frame_valid === 1'b1 && frame_ready === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected frame", 16'h0000, 16'hFFFF);
      else check("frame_word", exp_q.pop_front(), frame_word);
    end
  end

  // one access of n clocks; the expected frame is queued before deselect lands
  task automatic run(input int n, input logic sl);
    logic [63:0] w, got;
    logic so0, oe0, si0;
    logic [15:0] rsp;
    logic [15:0] mask;
    w = {$urandom, $urandom};
    rsp = 16'($urandom);
    si0 = 1'($urandom_range(1));
    response_word = frame_s'(rsp);
    sleep_mode = sl;
    mask = (n >= 32) ? 16'hFFFF : 16'((32'h1 << (n - 16)) - 32'h1);
    // a ready consumer empties the buffer long before this frame arrives
    if (!sl && good_len(n) && (exp_q.size() < 3 || frame_ready)) exp_q.push_back(w[15:0]);
    spi_master_model_i.xfer(n, w, si0, got, so0, oe0);
    check("oe at select", {15'h0, ~sl}, {15'h0, oe0});
    if (!sl) check("first data out", {15'h0, flag_exp | si0}, {15'h0, so0});
    if (!sl && n >= 16) check("response", rsp, 16'(got >> (n - 16)));
    if (!sl && n > 16) check("chain through", w[31:16] & mask, got[15:0] & mask);
    if (!sl && !good_len(n)) flag_exp = 1'b1;
    check("error flag", {15'h0, flag_exp}, {15'h0, frame_length_error_flag});
    check("oe released", 16'h0000, {15'h0, serial_out_oe});
  endtask : run

  initial begin
    arst_n = 1'b0;
    sleep_mode = 1'b0;
    error_clear = 1'b0;
    frame_ready = 1'b1;
    response_word = frame_s'(16'h0000);
    failures = 0;
    samples_checked = 0;
    flag_exp = 1'b0;
    void'($urandom(94));
    repeat (4) @(posedge clk);
    #2 arst_n = 1'b1;
    spi_master_model_i.wait_clk(4);
    check("flag after reset", 16'h0000, {15'h0, frame_length_error_flag});
    foreach (lens[i]) run(lens[i], 1'b0);
    error_clear = 1'b1;
    spi_master_model_i.wait_clk(1);
    error_clear = 1'b0;
    flag_exp = 1'b0;
    spi_master_model_i.wait_clk(2);
    check("flag cleared", 16'h0000, {15'h0, frame_length_error_flag});
    run(16, 1'b1);
    spi_master_model_i.noise(20);
    check("oe while idle", 16'h0000, {15'h0, serial_out_oe});
    frame_ready = 1'b0;
    repeat (4) run(16, 1'b0);
    frame_ready = 1'b1;
    spi_master_model_i.wait_clk(10);
    check("frames left", 16'h0000, 16'(exp_q.size()));
    repeat (3) begin
      frame_ready = 1'($urandom_range(1));
      run(16 + 8 * $urandom_range(2), 1'($urandom_range(3) == 0));
    end
    frame_ready = 1'b1;
    spi_master_model_i.wait_clk(10);
    check("frames left", 16'h0000, 16'(exp_q.size()));
    complete_run();
  end
endmodule : testbench
